// file: verilog/mem_datapath.sv
// Memory data path: write mux and latch, parity generate/check, read register, lockout.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Fast-bus write word goes to the mux when fast request selected, else system word.
// - Write data register follows input while latch pulse low, holds at its rise.
// - Word write latches two parity bits: bit 17 high byte, bit 16 low byte.
// - Byte write generates and stores only the parity bit of the written byte.
// - Address bit 0 picks the byte strobe; word write issues both strobes.
// - Fast-bus read data held in an 18-bit latch plus output buffer.
// - System-bus read data goes straight from sense lines to system drivers.
// - Read register captures sense data exactly once per memory read, when latch raised; parity register reads skip it.
// - Low 16 read bits driven on the fast bus only while its flag enables.
// - Stages 16 and 17 hold low and high byte parity for the checkers.
// - Each byte of fast-bus read data is checked against its own parity bit.
// - Requests from both buses are arbitrated, then the winner's cycle runs fully.
// - Internal refresh cycles run only when attached to dynamic MOS memory.
// - After a memory read-pause, all other requests locked out until the next cycle.
// - Fast-bus read parity errors are reported; a control enables detection.
// - Wrong-parity control set makes writes store odd parity.
// - Parity register answers at one of 16 addresses from octal 772100, by straps.
// - Decoder compares high octal digits fixed and low two digits from straps.
// - Address match with sync on a read gates the parity register onto system data.
// - Address match on a write strobes bus data into the parity register.
// - Parity register is whole-word only; byte writes do not update it.
module mem_datapath
    import mem_datapath_pkg::*;
(
    input wire logic ref_clk, // 125 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic [31:0] hrdata, // AHB read data
    output logic hresp, // AHB response, always OKAY
    input wire logic fastReq, // fast-bus request level
    input wire op_e fastOp, // fast-bus cycle type
    input wire logic fastAddr0, // fast-bus address bit 0
    input wire logic [15:0] fastWriteWord, // fast-bus write data
    output logic fastDone, // fast-bus cycle done pulse
    output logic [15:0] fastReadData, // fast-bus read data
    output logic fastDataOe, // fast-bus data drive enable
    output logic parityErr, // fast-bus read parity error pulse
    input wire logic sysSync, // system-bus master sync level
    input wire op_e sysOp, // system-bus cycle type
    input wire logic [17:0] sysAddr, // system-bus address
    input wire logic [15:0] sysWriteWord, // system-bus write data
    output logic sysDone, // system-bus cycle done pulse
    output logic [15:0] sysReadData, // system-bus read data
    output logic sysDataOe, // system-bus data drive enable
    input wire logic [17:0] memSenseWord, // memory sense lines with parity
    output logic [17:0] memWriteData, // latched write data with parity
    output logic memStrobeHi, // high byte write strobe
    output logic memStrobeLo, // low byte write strobe
    output logic memRefresh, // refresh cycle pulse
    input wire logic [3:0] parAddrStraps // parity register address straps
);
    // ==========================================================
    // State
    typedef struct packed {
        pins_s sync1;
        pins_s sync2;
        state_e fsm;
        logic grantFast;
        logic isReg;
        op_e op;
        logic addr0;
        logic latchPulse;
        logic [15:0] dataReg;
        logic [1:0] parBits;
        logic saLatch;
        logic [17:0] outReg;
        logic fastEn;
        logic sysEn;
        logic [15:0] sysData;
        logic strobeHi;
        logic strobeLo;
        logic [15:0] parityReg;
        logic fastDone;
        logic sysDone;
        logic parityErr;
        logic refreshPulse;
        logic [11:0] refCnt;
        logic refPend;
        logic dynMos;
        logic ahbPend;
        logic ahbWr;
        logic [7:0] ahbAddr;
        logic [31:0] hrdata;
    } st_s;

    st_s q;
    st_s n;
    pins_s pinsIn;
    pins_s s;
    logic [15:0] muxWord;
    logic wordOp;
    logic isRead;
    logic regMatch;
    logic errHi;
    logic errLo;

    assign pinsIn = '{fastReq: fastReq, fastOp: fastOp, fastAddr0: fastAddr0, fastWord: fastWriteWord,
                      sysSync: sysSync, sysOp: sysOp, sysAddr: sysAddr, sysWord: sysWriteWord,
                      sense: memSenseWord, straps: parAddrStraps};
    assign s = q.sync2;
    assign muxWord = q.grantFast ? s.fastWord : s.sysWord;
    assign wordOp = (q.op != OP_WRITEBYTE);
    assign isRead = (q.op == OP_READ) || (q.op == OP_READPAUSE);
    // fixed high digits, strapped low digits
    assign regMatch = (s.sysAddr[17:5] == PAR_BASE[17:5]) && (s.sysAddr[4:1] == s.straps);
    assign errHi = (^q.outReg[15:8]) ^ q.outReg[17];
    assign errLo = (^q.outReg[7:0]) ^ q.outReg[16];

    // ==========================================================
    // Next state
    always_comb begin
        n = q;
        n.sync1 = pinsIn;
        n.sync2 = q.sync1;
        n.fastDone = 1'b0;
        n.sysDone = 1'b0;
        n.parityErr = 1'b0;
        n.refreshPulse = 1'b0;
        n.strobeHi = 1'b0;
        n.strobeLo = 1'b0;
        n.saLatch = 1'b0;
        // transparent while the pulse is low
        if (!q.latchPulse) begin
            n.dataReg = muxWord;
            // both parity bits on word writes
            // only the written byte's bit on byte writes
            if (wordOp || q.addr0) begin
                n.parBits[1] = (^muxWord[15:8]) ^ q.parityReg[PAR_WRONG_BIT];
            end
            if (wordOp || !q.addr0) begin
                n.parBits[0] = (^muxWord[7:0]) ^ q.parityReg[PAR_WRONG_BIT];
            end
        end
        if (q.saLatch) begin
            n.outReg = s.sense;
        end
        if (q.dynMos) begin
            if (q.refCnt == REFRESH_CYC - 12'h001) begin
                n.refCnt = 12'h000;
                n.refPend = 1'b1;
            end else begin
                n.refCnt = q.refCnt + 12'h001;
            end
        end else begin
            n.refCnt = 12'h000;
            n.refPend = 1'b0;
        end
        unique case (q.fsm)
            // refresh, then fast bus, then system bus
            ST_IDLE: begin
                if (q.refPend && q.dynMos) begin
                    // A new request from the counter in this same cycle survives the grant.
                    n.refPend = (q.refCnt == REFRESH_CYC - 12'h001);
                    n.fsm = ST_REFRESH;
                end else if (s.fastReq) begin
                    n.grantFast = 1'b1;
                    n.op = s.fastOp;
                    n.addr0 = s.fastAddr0;
                    n.isReg = 1'b0;
                    n.fsm = ST_SETUP;
                end else if (s.sysSync) begin
                    n.grantFast = 1'b0;
                    n.op = s.sysOp;
                    n.addr0 = s.sysAddr[0];
                    n.isReg = regMatch;
                    n.fsm = ST_SETUP;
                end
            end
            ST_SETUP: begin
                n.latchPulse = !isRead;
                n.saLatch = isRead && !q.isReg;
                n.fsm = ST_STROBE;
            end
            ST_STROBE: begin
                if (q.isReg) begin
                    if (isRead) begin
                        n.sysData = q.parityReg;
                        n.sysEn = 1'b1;
                    end else if (q.op == OP_WRITE) begin
                        n.parityReg = s.sysWord;
                    end
                end else if (!isRead) begin
                    // byte strobe by address bit 0
                    n.strobeHi = wordOp || q.addr0;
                    n.strobeLo = wordOp || !q.addr0;
                end else if (q.grantFast) begin
                    // drive only for the fast request
                    n.fastEn = 1'b1;
                end else begin
                    // system read bypasses the read register
                    n.sysData = s.sense[15:0];
                    n.sysEn = 1'b1;
                end
                n.fsm = ST_DONE;
            end
            ST_DONE: begin
                n.fastDone = q.grantFast;
                n.sysDone = !q.grantFast;
                if (q.grantFast && isRead && q.parityReg[PAR_CHKEN_BIT] && (errHi || errLo)) begin
                    n.parityErr = 1'b1;
                    n.parityReg[PAR_ERR_BIT] = 1'b1;
                end
                n.fsm = ST_RELEASE;
            end
            ST_RELEASE: begin
                if ((q.grantFast && !s.fastReq) || (!q.grantFast && !s.sysSync)) begin
                    n.fastEn = 1'b0;
                    n.sysEn = 1'b0;
                    n.latchPulse = 1'b0;
                    n.fsm = (q.op == OP_READPAUSE && !q.isReg) ? ST_PAUSE : ST_IDLE;
                end
            end
            // only the pausing master may start the next cycle
            // the follow-up is normally a write, not enforced here
            ST_PAUSE: begin
                if (q.grantFast && s.fastReq) begin
                    n.op = s.fastOp;
                    n.addr0 = s.fastAddr0;
                    n.fsm = ST_SETUP;
                end else if (!q.grantFast && s.sysSync) begin
                    n.op = s.sysOp;
                    n.addr0 = s.sysAddr[0];
                    n.isReg = regMatch;
                    n.fsm = ST_SETUP;
                end
            end
            ST_REFRESH: begin
                n.refreshPulse = 1'b1;
                n.fsm = ST_IDLE;
            end
            // The three-bit state has one unused code; it falls back to idle.
            default: n.fsm = ST_IDLE;
        endcase
        // AHB data phase write, then address phase capture.
        if (q.ahbPend && q.ahbWr && q.ahbAddr == CTRL_OFS) begin
            n.dynMos = hwdata[CTRL_DYNMOS_BIT];
        end
        n.ahbPend = hsel && htrans[1] && hready;
        if (n.ahbPend) begin
            n.ahbWr = hwrite;
            n.ahbAddr = haddr[7:0];
            n.hrdata = 32'h0000_0000;
            if (!hwrite) begin
                unique case (haddr[7:0])
                    CTRL_OFS: n.hrdata[CTRL_DYNMOS_BIT] = q.dynMos;
                    STATUS_OFS: begin
                        n.hrdata[STAT_BUSY_BIT] = (q.fsm != ST_IDLE);
                        n.hrdata[STAT_LOCK_BIT] = (q.fsm == ST_PAUSE);
                        n.hrdata[STAT_FAST_BIT] = q.grantFast;
                    end
                    PARREG_OFS: n.hrdata[15:0] = q.parityReg;
                    default: n.hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '0;
            q.fsm <= ST_IDLE;
            q.op <= OP_READ;
            q.parityReg <= PARREG_RESET;
            q.dynMos <= CTRL_DYNMOS_RESET;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign fastDone = q.fastDone;
    assign fastReadData = q.outReg[15:0];
    assign fastDataOe = q.fastEn;
    assign parityErr = q.parityErr;
    assign sysDone = q.sysDone;
    assign sysReadData = q.sysData;
    assign sysDataOe = q.sysEn;
    assign memWriteData = {q.parBits, q.dataReg};
    assign memStrobeHi = q.strobeHi;
    assign memStrobeLo = q.strobeLo;
    assign memRefresh = q.refreshPulse;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence sReadStart;
        q.fsm == ST_SETUP && !q.isReg && (q.op == OP_READ || q.op == OP_READPAUSE);
    endsequence

    chk_mux_fast_route: assert property (q.fsm == ST_SETUP && q.grantFast && !q.latchPulse
        |=> q.dataReg == $past(s.fastWord)) else $error("fast write word not latched");
    chk_latch_hold: assert property (q.latchPulse && $past(q.latchPulse) |-> $stable(q.dataReg))
        else $error("write latch changed while closed");
    chk_word_parity: assert property (q.fsm == ST_STROBE && q.op == OP_WRITE && !q.parityReg[PAR_WRONG_BIT]
        |-> q.parBits == {^q.dataReg[15:8], ^q.dataReg[7:0]}) else $error("word parity wrong");
    chk_wrong_parity: assert property (q.fsm == ST_STROBE && q.op == OP_WRITE && q.parityReg[PAR_WRONG_BIT]
        |-> q.parBits == ~{^q.dataReg[15:8], ^q.dataReg[7:0]}) else $error("wrong parity not stored");
    chk_byte_strobe: assert property (q.strobeHi && q.strobeLo |-> q.op == OP_WRITE)
        else $error("byte write issued both strobes");
    chk_sense_once: assert property (sReadStart |=> q.saLatch ##1 !q.saLatch)
        else $error("sense latch not a single pulse");
    chk_sense_capture: assert property (q.saLatch |=> q.outReg == $past(s.sense))
        else $error("read register missed sense data");
    chk_fast_drive: assert property (q.fastEn |-> q.grantFast)
        else $error("fast bus driven for system cycle");
    chk_pause_lock: assert property (q.fsm == ST_PAUSE
        |=> (q.fsm == ST_PAUSE || q.fsm == ST_SETUP) && q.grantFast == $past(q.grantFast))
        else $error("lockout broken after read pause");
    chk_err_report: assert property (q.fsm == ST_DONE && q.grantFast && q.op == OP_READ
        && q.parityReg[PAR_CHKEN_BIT] && errLo |=> parityErr)
        else $error("parity error not reported");
endmodule : mem_datapath

`default_nettype wire

// file: shared/mem_datapath_pkg.sv
// Shared constants and types for the memory data path and parity block.
`default_nettype none
package mem_datapath_pkg;
    // ==========================================================
    // Register bus offsets (byte addresses) and reset values
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PARREG_OFS = 8'h08;
    localparam logic [15:0] PARREG_RESET = 16'h0000;
    localparam logic CTRL_DYNMOS_RESET = 1'b0;
    // ==========================================================
    // Field positions
    localparam int CTRL_DYNMOS_BIT = 0;
    localparam int PAR_CHKEN_BIT = 0;
    localparam int PAR_WRONG_BIT = 2;
    localparam int PAR_ERR_BIT = 15;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_FAST_BIT = 2;
    // Parity register base address, octal 772100.
    localparam logic [17:0] PAR_BASE = 18'h3f440;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int REFRESH_NS = 15600;
    localparam logic [11:0] REFRESH_CYC = 12'(REFRESH_NS / CLK_PERIOD_NS);
    // ==========================================================
    // Types
    typedef enum logic [1:0] {OP_READ, OP_READPAUSE, OP_WRITE, OP_WRITEBYTE} op_e;
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_DONE, ST_RELEASE, ST_PAUSE, ST_REFRESH} state_e;
    typedef struct packed {
        logic fastReq;
        op_e fastOp;
        logic fastAddr0;
        logic [15:0] fastWord;
        logic sysSync;
        op_e sysOp;
        logic [17:0] sysAddr;
        logic [15:0] sysWord;
        logic [17:0] sense;
        logic [3:0] straps;
    } pins_s;
endpackage : mem_datapath_pkg
`default_nettype wire

// file: sim/mem_word_model.sv
// One-word memory array model that drives the sense lines from its stored cell.
`timescale 1ns/1ps
`default_nettype none
module mem_word_model (
    input wire logic ref_clk, // clock
    input wire logic [17:0] memWriteData, // write data with parity
    input wire logic memStrobeHi, // high byte strobe
    input wire logic memStrobeLo, // low byte strobe
    output logic [17:0] memSenseWord // stored word with parity
);
    logic [17:0] cell_q = 18'h00000;
    assign memSenseWord = cell_q;
    // byte lanes: each strobe stores its own byte and parity bit.
    always_ff @(posedge ref_clk) begin
        if (memStrobeHi) begin
            cell_q[17] <= memWriteData[17];
            cell_q[15:8] <= memWriteData[15:8];
        end
        if (memStrobeLo) begin
            cell_q[16] <= memWriteData[16];
            cell_q[7:0] <= memWriteData[7:0];
        end
    end
endmodule : mem_word_model
`default_nettype wire

// file: sim/dual_port_memory_data_path_parity_tb.sv
// Self-checking bench for the memory data path with a one-word memory model.
`timescale 1ns/1ps
`default_nettype none
module dual_port_memory_data_path_parity_tb;
    import mem_datapath_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, fastDone, fastDataOe, parityErr, sysDone, sysDataOe;
    logic memStrobeHi, memStrobeLo, memRefresh;
    logic [31:0] hrdata, rd, e;
    logic [15:0] fastReadData, sysReadData, w, v;
    logic [17:0] memSenseWord, memWriteData, parAddr;
    logic fastReq = 1'b0;
    op_e fastOp = OP_READ;
    logic fastAddr0 = 1'b0;
    logic [15:0] fastWriteWord = 16'h0;
    logic sysSync = 1'b0;
    op_e sysOp = OP_READ;
    logic [17:0] sysAddr = 18'h0;
    logic [15:0] sysWriteWord = 16'h0;
    logic [3:0] straps = 4'h0;
    logic wp = 1'b0;
    int bad_count = 0;
    int n_checks = 0;
    int refCnt = 0;
    int sysCnt = 0;
    int c0;
    logic [31:0] fq[$], sq[$], wq[$];

    mem_datapath u_mem_datapath (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fastReq(fastReq), .fastOp(fastOp),
        .fastAddr0(fastAddr0), .fastWriteWord(fastWriteWord), .fastDone(fastDone),
        .fastReadData(fastReadData), .fastDataOe(fastDataOe), .parityErr(parityErr),
        .sysSync(sysSync), .sysOp(sysOp), .sysAddr(sysAddr), .sysWriteWord(sysWriteWord),
        .sysDone(sysDone), .sysReadData(sysReadData), .sysDataOe(sysDataOe),
        .memSenseWord(memSenseWord), .memWriteData(memWriteData), .memStrobeHi(memStrobeHi),
        .memStrobeLo(memStrobeLo), .memRefresh(memRefresh), .parAddrStraps(straps));
    mem_word_model u_mem_word_model (.ref_clk(ref_clk), .memWriteData(memWriteData),
        .memStrobeHi(memStrobeHi), .memStrobeLo(memStrobeLo), .memSenseWord(memSenseWord));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // Results are judged on the falling edge so that registered outputs have settled.
    always @(negedge ref_clk) begin
        if (fastDone === 1'b1 && fastDataOe === 1'b1) check({15'h0, parityErr, fastReadData}, fq.pop_front());
        if (sysDone === 1'b1) sysCnt++;
        if (sysDone === 1'b1 && sysDataOe === 1'b1) check({16'h0, sysReadData}, sq.pop_front());
        if (memRefresh === 1'b1) refCnt++;
        if (memStrobeHi === 1'b1 || memStrobeLo === 1'b1) begin
            e = wq.pop_front();
            check({e[31], 11'h0, memStrobeHi, memStrobeLo, e[31] ? memWriteData : 18'h0}, e);
        end
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        final_report();
    end

    // ==========================================================
    // Bus drivers
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : ahb

    // Word writes note the strobes and latched word they must produce, byte writes only the strobes; reads note their data.
    task automatic note(input op_e op, input logic a0, input logic [15:0] d, input logic [31:0] ex, input logic sys);
        if (op == OP_WRITE) wq.push_back({1'b1, 11'h0, 2'b11, ^d[15:8] ^ wp, ^d[7:0] ^ wp, d});
        else if (op == OP_WRITEBYTE) wq.push_back({1'b0, 11'h0, a0, !a0, 18'h0});
        else if (sys) sq.push_back(ex);
        else fq.push_back(ex);
    endtask : note

    task automatic fast(input op_e op, input logic a0, input logic [15:0] d, input logic [31:0] ex);
        note(op, a0, d, ex, 1'b0);
        @(posedge ref_clk);
        fastOp <= op;
        fastAddr0 <= a0;
        fastWriteWord <= d;
        fastReq <= 1'b1;
        do @(negedge ref_clk); while (fastDone !== 1'b1);
        @(posedge ref_clk);
        fastReq <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : fast

    task automatic sys(input op_e op, input logic [17:0] a, input logic [15:0] d, input logic [31:0] ex);
        if (a[17:1] != parAddr[17:1] || op < OP_WRITE) note(op, a[0], d, ex, 1'b1);
        @(posedge ref_clk);
        sysOp <= op;
        sysAddr <= a;
        sysWriteWord <= d;
        sysSync <= 1'b1;
        do @(negedge ref_clk); while (sysDone !== 1'b1);
        @(posedge ref_clk);
        sysSync <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : sys

    // ==========================================================
    // Scenarios
    initial begin
        rd = $urandom(93578);
        straps = 4'($urandom);
        parAddr = PAR_BASE | {13'h0, straps, 1'b0};
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ahb(1'b0, PARREG_OFS, 32'h0, rd);
        check(rd, 32'h0);
        ahb(1'b1, 8'h0c, 32'hffffffff, rd);
        ahb(1'b0, 8'h0c, 32'h0, rd);
        check(rd, 32'h0);
        w = 16'($urandom);
        fast(OP_WRITE, 1'b0, w, 32'h0);
        fast(OP_READ, 1'b0, 16'h0, {16'h0, w});
        w = 16'($urandom);
        sys(OP_WRITE, 18'h00100, w, 32'h0);
        sys(OP_READ, 18'h00100, 16'h0, {16'h0, w});
        fast(OP_READ, 1'b0, 16'h0, {16'h0, w});
        sys(OP_WRITE, parAddr ^ 18'h2, 16'h0001, 32'h0);
        ahb(1'b0, PARREG_OFS, 32'h0, rd);
        check(rd, 32'h0);
        sys(OP_WRITE, parAddr | 18'h1, 16'h0005, 32'h0);
        wp = 1'b1;
        sys(OP_WRITEBYTE, parAddr, 16'h0000, 32'h0);
        ahb(1'b0, PARREG_OFS, 32'h0, rd);
        check(rd, 32'h5);
        sys(OP_READ, parAddr, 16'h0, 32'h5);
        sys(OP_READPAUSE, parAddr, 16'h0, 32'h5);
        w = 16'($urandom);
        fast(OP_WRITE, 1'b0, w, 32'h0);
        fast(OP_READ, 1'b0, 16'h0, {15'h0, 1'b1, w});
        ahb(1'b0, PARREG_OFS, 32'h0, rd);
        check(rd, 32'h8005);
        sys(OP_WRITE, parAddr, 16'h0001, 32'h0);
        wp = 1'b0;
        w = 16'($urandom);
        v = 16'($urandom);
        fast(OP_WRITE, 1'b0, w, 32'h0);
        fast(OP_WRITEBYTE, 1'b1, v, 32'h0);
        fast(OP_READ, 1'b0, 16'h0, {16'h0, v[15:8], w[7:0]});
        fast(OP_WRITEBYTE, 1'b0, v, 32'h0);
        fast(OP_READ, 1'b0, 16'h0, {16'h0, v});
        sys(OP_WRITE, parAddr, 16'h0004, 32'h0);
        wp = 1'b1;
        fast(OP_WRITE, 1'b0, w, 32'h0);
        fast(OP_READ, 1'b0, 16'h0, {16'h0, w});
        sys(OP_WRITE, parAddr, 16'h0001, 32'h0);
        wp = 1'b0;
        fast(OP_READ, 1'b0, 16'h0, {15'h0, 1'b1, w});
        fast(OP_WRITE, 1'b0, v, 32'h0);
        fast(OP_READPAUSE, 1'b0, 16'h0, {16'h0, v});
        c0 = sysCnt;
        fork
            sys(OP_READ, 18'h00100, 16'h0, {16'h0, w});
            begin
                repeat (30) @(posedge ref_clk);
                check(32'(sysCnt), 32'(c0));
                ahb(1'b0, STATUS_OFS, 32'h0, rd);
                check(rd, 32'h7);
                // after 30 cycles and a status read, the pausing master follows with a write.
                fast(OP_WRITE, 1'b0, w, 32'h0);
            end
        join
        check(32'(refCnt), 32'h0);
        ahb(1'b1, CTRL_OFS, 32'h1, rd);
        repeat (2100) @(posedge ref_clk);
        check(32'(refCnt != 0), 32'h1);
        final_report();
    end
endmodule : dual_port_memory_data_path_parity_tb
`default_nettype wire
